// *** core/sflash_pkg.sv ***
/*
  shared constants for the sector unlock / in-band reset front end and its host.
  assumes a 125 MHz system clock on both ends.
*/
package sflash_pkg;
  // ----------------------------------------
  // opcodes and address fields
  // ----------------------------------------
  localparam logic [7:0] OP_UNLOCK = 8'h26;
  localparam logic [7:0] OP_RELOCK = 8'h24;
  localparam int ADDR_W = 24;
  localparam int SECT_LSB = 12;
  localparam int BLK_LSB = 16;
  localparam int BLK_W = 3;
  localparam int OP_BITS = 8;
  localparam int FULL_BITS = 32;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS = 8;
  localparam int CSL_NS = 500;
  localparam int CSH_NS = 500;
  localparam int RST_BUSY_NS = 1000;
  localparam int CSL_CYC = (CSL_NS + CLK_NS - 1) / CLK_NS;
  localparam int CSH_CYC = (CSH_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_CYC = (RST_BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCK_HALF = 10;
  // ----------------------------------------
  // host registers
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam int CTRL_UNLOCK = 0;
  localparam int CTRL_RELOCK = 1;
  localparam int CTRL_IBR = 2;
  localparam int STAT_BUSY = 0;
  localparam logic [23:0] ADDR_RST = 24'h000000;
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_SHIFT = 3'b001,
    H_TAIL = 3'b010,
    H_IBR_LO = 3'b011,
    H_IBR_HI = 3'b100
  } host_state_e;
endpackage

// *** core/sflash_if.sv ***
/*
  serial link between host controller and flash front end.
  assumes io0 is pulled high when nobody drives it.
*/
`timescale 1ns/1ps
interface sflash_if;
  logic cs_n;
  logic sck;
  logic host_io0_o;
  logic host_io0_oe_n;
  logic dev_io0_o;
  logic dev_io0_oe_n;
  logic io0;
  // resolved level of data_line_zero
  assign io0 = !host_io0_oe_n ? host_io0_o : (!dev_io0_oe_n ? dev_io0_o : 1'b1);
  modport host (output cs_n, output sck, output host_io0_o, output host_io0_oe_n);
  modport device (input cs_n, input sck, input io0, output dev_io0_o, output dev_io0_oe_n);
endinterface

// *** core/sync2.sv ***
/*
  two flip-flop synchroniser, one per bit.
  assumes inputs are levels from another domain.
*/
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_ff <= '0;
      q <= '0;
    end
    else
    begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule // sync2

// *** core/flash_front.sv ***
/*
  flash front end: sector unlock/relock commands and in-band reset detector.
  assumes sck from the host, a free-running 125 MHz clk, protect bits on clk.
*/
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
// What this block and the host do
// [RULE1] unlock 26h plus address, low twelve ignored
// [RULE2] unlock only acts inside protected blocks
// [RULE3] one unlocked sector; relock before another
// [RULE4] writes in protected blocks allowed only in unlocked sector
// [RULE5] relock 24h, no address, relocks sector
// [RULE6] reset uses only chip select, io0
// [RULE7] host keeps sck still during reset
// [RULE8] host sets io0 with chip select fall
// [RULE9] io0 not driven before first sck edge
// [RULE10] io0 sampled at each chip select rise
// [RULE11] host sends low, high, low, high
// [RULE12] fourth good pulse starts internal reset
// [RULE13] reset detected from any state
// [RULE14] chip select ignored while resetting
// [RULE15] host uses reset only for recovery
// [RULE16] bad level or sck edge restarts tracking
module flash_front
  import sflash_pkg::*;
(
  // system clock and reset
  input wire logic clk,
  input wire logic rstn,
  // link
  sflash_if.device lnk,
  // protection inputs
  input wire logic block_protect_bit0,
  input wire logic block_protect_bit1,
  input wire logic block_protect_bit2,
  input wire logic block_protect_bit3,
  input wire logic [ADDR_W-1:0] chk_addr,
  // status outputs
  output logic wr_allow_ff,
  output logic unlocked_ff,
  output logic [ADDR_W-SECT_LSB-1:0] unlocked_sector_ff,
  output logic int_reset_ff
);
  // ----------------------------------------
  // link domain: command shifter
  // ----------------------------------------
  logic frame_rstn;
  logic [FULL_BITS-1:0] sr_ff;
  logic [5:0] cnt_ff;
  logic [FULL_BITS-1:0] cmd_word_ff;
  logic tog_ff;
  logic [FULL_BITS-1:0] word_in;

  assign frame_rstn = rstn & ~lnk.cs_n;
  assign word_in = {sr_ff[FULL_BITS-2:0], lnk.io0};

  always_ff @(posedge lnk.sck or negedge frame_rstn)
  begin
    if (!frame_rstn)
    begin
      sr_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      sr_ff <= word_in;
      if (cnt_ff != 6'(FULL_BITS))
      begin
        cnt_ff <= cnt_ff + 6'h01;
      end
    end
  end

  // held word survives the frame; handed over by toggle
  always_ff @(posedge lnk.sck or negedge rstn)
  begin
    if (!rstn)
    begin
      cmd_word_ff <= '0;
      tog_ff <= 1'b0;
    end
    else if (cnt_ff == 6'(OP_BITS - 1) && word_in[7:0] == OP_RELOCK)
    begin
      cmd_word_ff <= {OP_RELOCK, 24'h000000}; // [RULE5]
      tog_ff <= ~tog_ff;
    end
    else if (cnt_ff == 6'(FULL_BITS - 1) && word_in[31:24] == OP_UNLOCK)
    begin
      cmd_word_ff <= word_in; // [RULE1]
      tog_ff <= ~tog_ff;
    end
  end

  // ----------------------------------------
  // io0 output: this block never streams data
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lnk.dev_io0_o <= 1'b0;
      lnk.dev_io0_oe_n <= 1'b1;
    end
    else
    begin
      lnk.dev_io0_o <= 1'b0;
      lnk.dev_io0_oe_n <= 1'b1; // [RULE9]
    end
  end

  // ----------------------------------------
  // crossing into clk domain
  // ----------------------------------------
  logic [3:0] sync_q;
  logic cs_s;
  logic io0_s;
  logic sck_s;
  logic tog_s;
  logic cs_d_ff;
  logic sck_d_ff;
  logic tog_d_ff;
  logic cs_rise;
  logic cs_fall;
  logic cmd_ev;

  sync2 #(.W(4)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d({~lnk.cs_n, lnk.io0, lnk.sck, tog_ff}), // [RULE6]
    .q(sync_q)
  );
  // select is carried inverted so the reset value of the synchroniser is the idle level
  assign cs_s = ~sync_q[3];
  assign {io0_s, sck_s, tog_s} = sync_q[2:0];
  assign cs_rise = cs_s & ~cs_d_ff;
  assign cs_fall = ~cs_s & cs_d_ff;
  assign cmd_ev = tog_s ^ tog_d_ff;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cs_d_ff <= 1'b1;
      sck_d_ff <= 1'b0;
      tog_d_ff <= 1'b0;
    end
    else
    begin
      cs_d_ff <= cs_s;
      sck_d_ff <= sck_s;
      tog_d_ff <= tog_s;
    end
  end

  // ----------------------------------------
  // in-band reset detector
  // ----------------------------------------
  logic [1:0] stage_ff;
  logic dirty_ff;
  logic rst_go;

  // sck movement inside a frame spoils the pattern
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dirty_ff <= 1'b0;
    end
    else if (cs_fall)
    begin
      dirty_ff <= 1'b0;
    end
    else if (!cs_s && sck_s != sck_d_ff)
    begin
      dirty_ff <= 1'b1; // [RULE16]
    end
  end

  assign rst_go = cs_rise && !int_reset_ff && !dirty_ff && io0_s == stage_ff[0]
    && stage_ff == 2'h3;

  // tracker runs regardless of command state
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stage_ff <= 2'h0;
    end
    else if (int_reset_ff)
    begin
      stage_ff <= 2'h0; // [RULE14]
    end
    else if (cs_rise) // [RULE13]
    begin
      if (dirty_ff || io0_s != stage_ff[0]) // [RULE10]
      begin
        stage_ff <= (!dirty_ff && !io0_s) ? 2'h1 : 2'h0; // [RULE16]
      end
      else
      begin
        stage_ff <= stage_ff + 2'h1;
      end
    end
  end

  // ----------------------------------------
  // internal reset timer
  // ----------------------------------------
  logic [$clog2(RST_CYC+1)-1:0] rst_cnt_ff;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      int_reset_ff <= 1'b0;
      rst_cnt_ff <= '0;
    end
    else if (rst_go)
    begin
      int_reset_ff <= 1'b1; // [RULE12]
      rst_cnt_ff <= '0;
    end
    else if (int_reset_ff)
    begin
      rst_cnt_ff <= rst_cnt_ff + 1'b1;
      if (rst_cnt_ff == ($bits(rst_cnt_ff))'(RST_CYC - 1))
      begin
        int_reset_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // protection and sector unlock state
  // ----------------------------------------
  logic [3:0] bp;
  logic [BLK_W:0] prot_cnt;
  logic tgt_prot;
  logic chk_prot;
  logic [ADDR_W-1:0] cmd_addr;

  assign bp = {block_protect_bit3, block_protect_bit2, block_protect_bit1,
    block_protect_bit0};
  // bp = n protects the top 2^(n-1) blocks
  assign prot_cnt = (bp == 4'h0) ? '0 :
    (bp > 4'(BLK_W + 1)) ? (BLK_W+1)'(1 << BLK_W) : (BLK_W+1)'(1 << (bp - 4'h1));
  assign cmd_addr = cmd_word_ff[ADDR_W-1:0];

  function automatic logic is_prot(input logic [ADDR_W-1:0] a, input logic [BLK_W:0] n);
    is_prot = ({1'b0, a[BLK_LSB+BLK_W-1:BLK_LSB]} + n) > (BLK_W+1)'((1 << BLK_W) - 1);
  endfunction

  assign tgt_prot = is_prot(cmd_addr, prot_cnt);
  assign chk_prot = is_prot(chk_addr, prot_cnt);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      unlocked_ff <= 1'b0;
      unlocked_sector_ff <= '0;
    end
    else if (int_reset_ff)
    begin
      unlocked_ff <= 1'b0;
    end
    else if (cmd_ev)
    begin
      if (cmd_word_ff[31:24] == OP_RELOCK)
      begin
        unlocked_ff <= 1'b0; // [RULE5]
      end
      else if (!unlocked_ff && tgt_prot) // [RULE2] [RULE3]
      begin
        unlocked_ff <= 1'b1;
        unlocked_sector_ff <= cmd_addr[ADDR_W-1:SECT_LSB]; // [RULE1]
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_allow_ff <= 1'b0;
    end
    else
    begin
      wr_allow_ff <= !int_reset_ff && (!chk_prot ||
        (unlocked_ff && chk_addr[ADDR_W-1:SECT_LSB] == unlocked_sector_ff)); // [RULE4]
    end
  end
endmodule // flash_front

// *** core/flash_host.sv ***
/*
  host controller: sends unlock/relock commands and the in-band reset pattern.
  assumes a register port on clk; sck is made here by a divider.
*/
`timescale 1ns/1ps
module flash_host
  import sflash_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // link
  sflash_if.host lnk
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [ADDR_W-1:0] addr_ff;
  host_state_e st_ff;
  logic busy;
  assign busy = st_ff != H_IDLE;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      addr_ff <= ADDR_RST;
      rdata <= '0;
    end
    else
    begin
      if (wr && addr == REG_ADDR)
      begin
        addr_ff <= wdata[ADDR_W-1:0];
      end
      rdata <= '0;
      if (rd && addr == REG_ADDR)
      begin
        rdata <= {8'h00, addr_ff};
      end
      else if (rd && addr == REG_STAT)
      begin
        rdata <= {31'h00000000, busy};
      end
    end
  end

  // ----------------------------------------
  // link sequencer
  // ----------------------------------------
  logic [FULL_BITS-1:0] sh_ff;
  logic [5:0] left_ff;
  logic [6:0] cnt_ff;
  logic [1:0] pulse_ff;
  logic go;
  assign go = wr && addr == REG_CTRL && !busy;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_ff <= H_IDLE;
      lnk.cs_n <= 1'b1;
      lnk.sck <= 1'b0;
      lnk.host_io0_o <= 1'b0;
      lnk.host_io0_oe_n <= 1'b1;
      sh_ff <= '0;
      left_ff <= '0;
      cnt_ff <= '0;
      pulse_ff <= '0;
    end
    else
    begin
      cnt_ff <= cnt_ff + 7'h01;
      case (st_ff)
        H_IDLE:
        begin
          cnt_ff <= '0;
          lnk.host_io0_oe_n <= 1'b1;
          if (go && wdata[CTRL_IBR])
          begin
            st_ff <= H_IBR_LO;
            pulse_ff <= 2'h0;
            lnk.cs_n <= 1'b0;
            lnk.host_io0_o <= 1'b0; // [RULE8] [RULE11]
            lnk.host_io0_oe_n <= 1'b0;
          end
          else if (go && (wdata[CTRL_UNLOCK] || wdata[CTRL_RELOCK]))
          begin
            st_ff <= H_SHIFT;
            sh_ff <= wdata[CTRL_UNLOCK] ? {OP_UNLOCK, addr_ff} : {OP_RELOCK, 24'h000000};
            lnk.host_io0_o <= wdata[CTRL_UNLOCK] ? OP_UNLOCK[7] : OP_RELOCK[7];
            left_ff <= wdata[CTRL_UNLOCK] ? 6'(FULL_BITS) : 6'(OP_BITS); // [RULE1] [RULE5]
            lnk.cs_n <= 1'b0;
            lnk.host_io0_oe_n <= 1'b0;
          end
        end
        H_SHIFT:
        begin
          if (cnt_ff == 7'(SCK_HALF - 1))
          begin
            cnt_ff <= '0;
            lnk.sck <= ~lnk.sck;
            if (lnk.sck)
            begin
              sh_ff <= {sh_ff[FULL_BITS-2:0], 1'b0};
              lnk.host_io0_o <= sh_ff[FULL_BITS-2];
              left_ff <= left_ff - 6'h01;
              if (left_ff == 6'h01)
              begin
                st_ff <= H_TAIL;
              end
            end
          end
        end
        H_TAIL:
        begin
          if (cnt_ff == 7'(SCK_HALF - 1))
          begin
            lnk.cs_n <= 1'b1;
            lnk.host_io0_oe_n <= 1'b1;
          end
          if (cnt_ff == 7'(SCK_HALF + CSH_CYC - 1))
          begin
            st_ff <= H_IDLE;
          end
        end
        H_IBR_LO:
        begin
          if (cnt_ff == 7'(CSL_CYC - 1)) // [RULE7]
          begin
            cnt_ff <= '0;
            lnk.cs_n <= 1'b1;
            st_ff <= H_IBR_HI;
          end
        end
        H_IBR_HI:
        begin
          if (cnt_ff == 7'(CSH_CYC - 1))
          begin
            cnt_ff <= '0;
            if (pulse_ff == 2'h3)
            begin
              st_ff <= H_IDLE;
              lnk.host_io0_oe_n <= 1'b1;
            end
            else
            begin
              pulse_ff <= pulse_ff + 2'h1;
              lnk.cs_n <= 1'b0;
              lnk.host_io0_o <= ~pulse_ff[0]; // [RULE8] [RULE11]
              st_ff <= H_IBR_LO;
            end
          end
        end
        default:
        begin
          st_ff <= H_IDLE;
          lnk.cs_n <= 1'b1;
        end
      endcase
    end
  end
endmodule // flash_host

// *** verif/sflash_monitor.sv ***
/*
  assertions on the serial link between host and flash front end.
  assumes the bench places it beside the link interface, on clk.
*/
`timescale 1ns/1ps
module sflash_monitor
  import sflash_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // link
  input wire logic cs_n,
  input wire logic sck,
  input wire logic host_io0_oe_n,
  input wire logic dev_io0_oe_n,
  input wire logic io0
);
  logic [7:0] dwell_ff;
  logic [5:0] rises_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn) dwell_ff <= 8'hFF;
    else if ($changed(cs_n)) dwell_ff <= 8'h01;
    else if (dwell_ff != 8'hFF) dwell_ff <= dwell_ff + 8'h01;
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn) rises_ff <= 6'h00;
    else if (cs_n) rises_ff <= 6'h00;
    else if ($rose(sck)) rises_ff <= rises_ff + 6'h01;
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_half_period;
    sck [*8] ##1 sck ##1 sck ##1 !sck;
  endsequence
  a_sck_idle: assert property (cs_n |-> !sck)
    else $error("sck moved while deselected");
  a_host_owns_io: assert property (!cs_n |-> !host_io0_oe_n)
    else $error("io0 not driven by host in frame");
  a_dev_io_quiet: assert property ($fell(cs_n) |-> dev_io0_oe_n [*8])
    else $error("device drove io0 before sck");
  a_first_edge_gap: assert property ($fell(cs_n) |-> !sck [*8])
    else $error("sck edge too soon after select");
  a_sck_half_period: assert property ($rose(sck) |-> s_half_period)
    else $error("sck high phase wrong");
  a_cs_low_width: assert property ($rose(cs_n) |-> dwell_ff >= CSL_CYC)
    else $error("select low too short");
  a_cs_high_width: assert property ($fell(cs_n) |-> dwell_ff >= CSH_CYC)
    else $error("select high too short");
  a_frame_bits: assert property ($rose(cs_n) |-> rises_ff inside {0, 8, 32})
    else $error("frame bit count wrong");
  a_reset_level_held: assert property ($rose(cs_n) && rises_ff == 6'h00 |-> $stable(io0))
    else $error("io0 moved at select rise");
endmodule // sflash_monitor

// *** verif/testbench.sv ***
/*
  self-checking bench: register port drives commands and in-band reset.
  assumes both ends on clk; sck made by the host divider.
*/
`timescale 1ns/1ps
module testbench
  import sflash_pkg::*;
;
  logic clk;
  logic rstn;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic [3:0] bp;
  logic [23:0] chk_addr;
  logic wr_allow_ff;
  logic unlocked_ff;
  logic [11:0] unlocked_sector_ff;
  logic int_reset_ff;
  logic note;
  logic note_d;
  logic snap;
  logic [31:0] exp_q[$];
  int failures;
  int samples_checked;
  sflash_if lnk ();
  flash_host u_flash_host (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .lnk(lnk));
  flash_front u_flash_front (.clk(clk), .rstn(rstn), .lnk(lnk),
    .block_protect_bit0(bp[0]), .block_protect_bit1(bp[1]), .block_protect_bit2(bp[2]),
    .block_protect_bit3(bp[3]), .chk_addr(chk_addr), .wr_allow_ff(wr_allow_ff),
    .unlocked_ff(unlocked_ff), .unlocked_sector_ff(unlocked_sector_ff),
    .int_reset_ff(int_reset_ff));
  sflash_monitor u_sflash_monitor (.clk(clk), .rstn(rstn), .cs_n(lnk.cs_n), .sck(lnk.sck),
    .host_io0_oe_n(lnk.host_io0_oe_n), .dev_io0_oe_n(lnk.dev_io0_oe_n), .io0(lnk.io0));
  // ----------------------------------------
  // clock, watchdog, watcher
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    failures++;
    end_sim();
  end
  always @(posedge clk) note_d <= note;
  always @(negedge clk)
  begin
    if (note_d) chk(rdata, exp_q.pop_front());
    if (snap) chk({16'h0000, int_reset_ff, unlocked_ff, wr_allow_ff, 1'b0,
      unlocked_ff ? unlocked_sector_ff : 12'h000}, exp_q.pop_front());
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] e);
    samples_checked++;
    if (seen !== e)
    begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, e);
    end
  endtask
  task automatic end_sim();
    if (failures == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    note <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    note <= 1'b0;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      addr <= REG_STAT;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      n++;
    end
    while (rdata[STAT_BUSY] !== 1'b0 && n < 3000);
    if (n >= 3000) failures++;
  endtask
  task automatic send(input int b);
    wr_reg(REG_CTRL, 32'h1 << b);
    wait_idle();
  endtask
  task automatic look(input logic [23:0] a, input logic [31:0] e);
    @(posedge clk);
    chk_addr <= a;
    repeat (2) @(posedge clk);
    snap <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    snap <= 1'b0;
  endtask
  function automatic logic [31:0] st(input logic un, input logic al, input logic [23:0] s);
    st = {16'h0000, 1'b0, un, al, 1'b0, un ? s[23:12] : 12'h000};
  endfunction
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    logic [23:0] a;
    logic [23:0] b;
    logic [23:0] c;
    int n;
    void'($urandom(45));
    rstn = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    note = 1'b0;
    snap = 1'b0;
    chk_addr = 24'h000000;
    bp = 4'(1 + $urandom % 3);
    failures = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(REG_STAT, 32'h0);
    rd_reg(REG_ADDR, {8'h00, ADDR_RST});
    rd_reg(8'h0C, 32'h0);
    a = {5'h00, 3'h7, 16'($urandom)};
    b = a ^ 24'h001000;
    c = {5'h00, 3'h0, 16'($urandom)};
    wr_reg(REG_ADDR, {8'h00, a});
    rd_reg(REG_ADDR, {8'h00, a});
    send(CTRL_UNLOCK);
    look(a, st(1, 1, a));
    look(a ^ 24'h000FFF, st(1, 1, a));
    look(b, st(1, 0, a));
    wr_reg(REG_ADDR, {8'h00, b});
    send(CTRL_UNLOCK);
    look(b, st(1, 0, a));
    send(CTRL_RELOCK);
    look(a, st(0, 0, a));
    send(CTRL_UNLOCK);
    look(b, st(1, 1, b));
    send(CTRL_RELOCK);
    wr_reg(REG_ADDR, {8'h00, c});
    send(CTRL_UNLOCK);
    look(c, st(0, 1, c));
    wr_reg(REG_CTRL, 32'h1 << CTRL_IBR);
    n = 0;
    while (int_reset_ff !== 1'b1 && n < 1000)
    begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (int_reset_ff === 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    chk(32'(n), 32'(RST_CYC));
    wait_idle();
    wr_reg(REG_ADDR, {8'h00, a});
    send(CTRL_UNLOCK);
    look(a, st(1, 1, a));
    end_sim();
  end
endmodule // testbench
